//--- rtl/dbvcp_pkg.sv
// constants, register map and carrier types for the bus protection block
// assumes voltages in units of 0.1 V and currents in whole percent of rating
package dbvcp_pkg;

	// ************************************************************
	// register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [15:0] IDX_LV_THRESH = 16'h0600;
	localparam logic [15:0] IDX_OV_LEVEL = 16'h0601;
	localparam logic [15:0] IDX_OV_METHOD = 16'h0602;
	localparam logic [15:0] IDX_OC_LEVEL = 16'h0603;
	localparam logic [15:0] IDX_CTRL = 16'h0610;
	localparam logic [15:0] IDX_STATUS = 16'h0611;
	localparam logic [15:0] IDX_IRQ_STAT = 16'h0612;
	localparam logic [15:0] IDX_IRQ_MASK = 16'h0613;
	localparam logic [15:0] IDX_CMD = 16'h0614;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_CT_BIT = 0;
	localparam int CTRL_RESTART_BIT = 1;
	localparam int CMD_RESET_BIT = 0;
	localparam int IRQ_W = 4;
	localparam int IRQ_UV_FAULT = 0;
	localparam int IRQ_UV_STOP = 1;
	localparam int IRQ_OV_STALL = 2;
	localparam int IRQ_OC_STALL = 3;

	// ************************************************************
	// voltage figures, 0.1 V per count; low / high voltage series
	// ************************************************************
	localparam logic [15:0] LV_DEF_LO = 16'h0708; // 180.0 V
	localparam logic [15:0] LV_DEF_HI = 16'h0e10; // 360.0 V
	localparam logic [15:0] HYST_LO = 16'h012c; // 30 V
	localparam logic [15:0] HYST_HI = 16'h0258; // 60 V
	localparam logic [15:0] OVS_DEF_LO = 16'h0ed8; // 380.0 V
	localparam logic [15:0] OVS_DEF_HI = 16'h1db0; // 760.0 V
	localparam logic [15:0] OV_FAULT_LO = 16'h1004; // 410 V
	localparam logic [15:0] OV_FAULT_HI = 16'h2008; // 820 V
	localparam logic [15:0] OC_CAP_V_LO = 16'h0dac; // 350 V
	localparam logic [15:0] OC_CAP_V_HI = 16'h1b58; // 700 V
	localparam logic [15:0] SMART_BAND = 16'h0064; // 10.0 V

	// ************************************************************
	// current figures, percent of rated current
	// ************************************************************
	localparam logic [15:0] OC_DEF_VT = 16'h0078; // 120 %
	localparam logic [15:0] OC_DEF_CT = 16'h00b4; // 180 %
	localparam logic [15:0] OC_MAX_VT = 16'h0096; // 150 %
	localparam logic [15:0] OC_MAX_CT = 16'h00c8; // 200 %
	localparam logic [15:0] OC_CAP_CT = 16'h00b9; // 185 %

	// ************************************************************
	// fault codes and bus answers
	// ************************************************************
	localparam logic [2:0] FC_NONE = 3'h0;
	localparam logic [2:0] FC_UV_ACCEL = 3'h1;
	localparam logic [2:0] FC_UV_DECEL = 3'h2;
	localparam logic [2:0] FC_UV_CONST = 3'h3;
	localparam logic [2:0] FC_UV_STOP = 3'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_NORMAL = 2'h0,
		ST_STOPWARN = 2'h1,
		ST_OPFAULT = 2'h2
	} dbvcp_state_t;

	typedef struct packed {
		logic [15:0] busVolt;
		logic [15:0] outCurrent;
	} dbvcp_meas_t;

	typedef struct packed {
		logic running;
		logic accel;
		logic decel;
	} dbvcp_run_t;

endpackage

//--- rtl/dbvcp_protect.sv
// bus voltage and current protection supervisor with an AXI4-Lite slave
// assumes measurements and run state come from logic on core_clk
//
// Notes on behaviour
// - bus voltage below the low-voltage threshold raises an undervoltage event.
// - undervoltage while running makes the output stop and the motor coast.
// - running undervoltage code tells acceleration, deceleration or constant speed.
// - a running undervoltage fault stays latched until a reset command.
// - with power-loss restart enabled the fault clears itself on recovery.
// - undervoltage while stopped has its own code and no history entry.
// - stopped undervoltage clears above threshold plus 30 V or 60 V.
// - an overvoltage stall level of zero turns overvoltage stall off.
// - a nonzero level turns it on; defaults 380.0 V or 760.0 V.
// - a level above the overvoltage fault level also turns it off.
// - method field: zero picks traditional, one picks smart stall.
// - traditional: pause deceleration while bus voltage is above the level.
// - smart: regulate deceleration to keep bus voltage steady below fault.
// - regenerative overvoltage stretches deceleration only while the stall holds the ramp.
// - acceleration freezes while output current exceeds the stall level.
// - acceleration stall level limited to 150 or 200 percent by torque mode.
// - constant torque with high bus voltage caps the level at 185 percent.
`timescale 1ns/100ps
`default_nettype none
module dbvcp_protect #(
	parameter bit HIGH_VOLT = 1'b0
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire dbvcp_pkg::dbvcp_meas_t meas,
	input wire dbvcp_pkg::dbvcp_run_t run,
	output logic coastReq,
	output logic rampHold,
	output logic rampExtend,
	output logic [2:0] faultCode,
	output logic stopWarn,
	output logic faultLog,
	output logic restartReq,
	output logic irq
);

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic isReg(input logic [15:0] a,
		input logic [15:0] idx);
		isReg = (a[15:2] == idx[13:0]);
	endfunction

	function automatic logic [15:0] minU16(input logic [15:0] a,
		input logic [15:0] b);
		minU16 = (a < b) ? a : b;
	endfunction

	function automatic logic [15:0] strobe16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		strobe16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	localparam logic [15:0] LV_DEF =
		HIGH_VOLT ? dbvcp_pkg::LV_DEF_HI : dbvcp_pkg::LV_DEF_LO;
	localparam logic [15:0] HYST =
		HIGH_VOLT ? dbvcp_pkg::HYST_HI : dbvcp_pkg::HYST_LO;
	localparam logic [15:0] OVS_DEF =
		HIGH_VOLT ? dbvcp_pkg::OVS_DEF_HI : dbvcp_pkg::OVS_DEF_LO;
	localparam logic [15:0] OV_FAULT =
		HIGH_VOLT ? dbvcp_pkg::OV_FAULT_HI : dbvcp_pkg::OV_FAULT_LO;
	localparam logic [15:0] OC_CAP_V =
		HIGH_VOLT ? dbvcp_pkg::OC_CAP_V_HI : dbvcp_pkg::OC_CAP_V_LO;

	// ************************************************************
	// bus handshake state
	// ************************************************************
	logic [15:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic wrEn;
	logic wrHit;
	logic rdHit;
	logic [31:0] rdVal;

	assign wrEn = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

	// write address and data are taken in either order, answer follows both
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= dbvcp_pkg::RESP_OKAY;
			awAddr_q <= 16'h0000;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid & s_axi_awready)
			begin
				s_axi_awready <= 1'b0;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				s_axi_wready <= 1'b0;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (wrEn)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrHit ? dbvcp_pkg::RESP_OKAY :
					dbvcp_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid & s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// read answer one cycle after the address is taken
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= dbvcp_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid & s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdVal;
			s_axi_rresp <= rdHit ? dbvcp_pkg::RESP_OKAY :
				dbvcp_pkg::RESP_SLVERR;
		end
		else if (s_axi_rvalid & s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ************************************************************
	// software registers
	// ************************************************************
	logic [15:0] lvThresh_q;
	logic [15:0] ovLevel_q;
	logic ovMethod_q;
	logic [15:0] ocLevel_q;
	logic torqueCt_q;
	logic restartEn_q;
	logic [dbvcp_pkg::IRQ_W-1:0] irqStat_q;
	logic [dbvcp_pkg::IRQ_W-1:0] irqMask_q;
	logic [dbvcp_pkg::IRQ_W-1:0] irqEvt;
	logic resetCmd;
	logic [15:0] ocMax;
	logic [15:0] ocWrite;

	assign ocMax = torqueCt_q ? dbvcp_pkg::OC_MAX_CT : dbvcp_pkg::OC_MAX_VT;
	assign ocWrite = minU16(strobe16(ocLevel_q, wData_q, wStrb_q), ocMax);
	assign resetCmd = wrEn & isReg(awAddr_q, dbvcp_pkg::IDX_CMD) &
		wStrb_q[0] & wData_q[dbvcp_pkg::CMD_RESET_BIT];
	assign wrHit = isReg(awAddr_q, dbvcp_pkg::IDX_LV_THRESH) |
		isReg(awAddr_q, dbvcp_pkg::IDX_OV_LEVEL) |
		isReg(awAddr_q, dbvcp_pkg::IDX_OV_METHOD) |
		isReg(awAddr_q, dbvcp_pkg::IDX_OC_LEVEL) |
		isReg(awAddr_q, dbvcp_pkg::IDX_CTRL) |
		isReg(awAddr_q, dbvcp_pkg::IDX_STATUS) |
		isReg(awAddr_q, dbvcp_pkg::IDX_IRQ_STAT) |
		isReg(awAddr_q, dbvcp_pkg::IDX_IRQ_MASK) |
		isReg(awAddr_q, dbvcp_pkg::IDX_CMD);

	// threshold, level and mode registers
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			lvThresh_q <= LV_DEF;
			ovLevel_q <= OVS_DEF;
			ovMethod_q <= 1'b0;
			ocLevel_q <= dbvcp_pkg::OC_DEF_VT;
			torqueCt_q <= 1'b0;
			restartEn_q <= 1'b0;
			irqMask_q <= '0;
		end
		else if (wrEn)
		begin
			if (isReg(awAddr_q, dbvcp_pkg::IDX_LV_THRESH))
				lvThresh_q <= strobe16(lvThresh_q, wData_q, wStrb_q);
			if (isReg(awAddr_q, dbvcp_pkg::IDX_OV_LEVEL))
				ovLevel_q <= strobe16(ovLevel_q, wData_q, wStrb_q);
			if (isReg(awAddr_q, dbvcp_pkg::IDX_OV_METHOD) & wStrb_q[0])
				ovMethod_q <= wData_q[0];
			if (isReg(awAddr_q, dbvcp_pkg::IDX_OC_LEVEL))
				ocLevel_q <= ocWrite;
			if (isReg(awAddr_q, dbvcp_pkg::IDX_CTRL) & wStrb_q[0])
			begin
				torqueCt_q <= wData_q[dbvcp_pkg::CTRL_CT_BIT];
				restartEn_q <= wData_q[dbvcp_pkg::CTRL_RESTART_BIT];
			end
			if (isReg(awAddr_q, dbvcp_pkg::IDX_IRQ_MASK) & wStrb_q[0])
				irqMask_q <= wData_q[dbvcp_pkg::IRQ_W-1:0];
		end
	end

	// sticky events, write one to clear, a new event wins over the clear
	always_ff @(posedge core_clk)
	begin
		if (srst)
			irqStat_q <= '0;
		else if (wrEn & isReg(awAddr_q, dbvcp_pkg::IDX_IRQ_STAT) & wStrb_q[0])
			irqStat_q <= (irqStat_q & ~wData_q[dbvcp_pkg::IRQ_W-1:0]) | irqEvt;
		else
			irqStat_q <= irqStat_q | irqEvt;
	end

	// interrupt line from unmasked sticky bits
	always_ff @(posedge core_clk)
	begin
		if (srst)
			irq <= 1'b0;
		else
			irq <= |(irqStat_q & irqMask_q);
	end

	// ************************************************************
	// protection comparisons, redone every cycle
	// ************************************************************
	dbvcp_pkg::dbvcp_state_t state_q;
	logic uvNow;
	logic [16:0] recoverLvl;
	logic recovered;
	logic ovEnable;
	logic tradHold;
	logic smartHold;
	logic [15:0] ocEff;
	logic ocHold;
	logic ovStall_q;
	logic ocStall_q;

	assign uvNow = meas.busVolt < lvThresh_q;
	assign recoverLvl = {1'b0, lvThresh_q} + {1'b0, HYST};
	assign recovered = {1'b0, meas.busVolt} > recoverLvl;
	// zero or above the fault level disables the stall
	assign ovEnable = (ovLevel_q != 16'h0000) && (ovLevel_q <= OV_FAULT);
	// traditional: pause while above the level
	assign tradHold = run.decel & ovEnable & ~ovMethod_q &
		(meas.busVolt > ovLevel_q);
	// smart: start pausing a band early so the bus stays steady
	assign smartHold = run.decel & ovEnable & ovMethod_q &
		({1'b0, meas.busVolt} + {1'b0, dbvcp_pkg::SMART_BAND} >
		{1'b0, ovLevel_q});
	// effective current level with the constant torque cap
	assign ocEff = (torqueCt_q && meas.busVolt > OC_CAP_V) ?
		minU16(minU16(ocLevel_q, ocMax), dbvcp_pkg::OC_CAP_CT) :
		minU16(ocLevel_q, ocMax);
	assign ocHold = run.accel & (meas.outCurrent > ocEff);

	// ramp control outputs
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			rampHold <= 1'b0;
			rampExtend <= 1'b0;
			ovStall_q <= 1'b0;
			ocStall_q <= 1'b0;
		end
		else
		begin
			rampHold <= tradHold | smartHold | ocHold;
			rampExtend <= tradHold | smartHold;
			ovStall_q <= tradHold | smartHold;
			ocStall_q <= ocHold;
		end
	end

	// ************************************************************
	// undervoltage state machine
	// ************************************************************
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			state_q <= dbvcp_pkg::ST_NORMAL;
			coastReq <= 1'b0;
			faultCode <= dbvcp_pkg::FC_NONE;
			stopWarn <= 1'b0;
			faultLog <= 1'b0;
			restartReq <= 1'b0;
		end
		else
		begin
			faultLog <= 1'b0;
			restartReq <= 1'b0;
			unique case (state_q)
				dbvcp_pkg::ST_NORMAL:
					if (uvNow & run.running)
					begin
						state_q <= dbvcp_pkg::ST_OPFAULT;
						coastReq <= 1'b1;
						faultLog <= 1'b1;
						faultCode <= run.accel ? dbvcp_pkg::FC_UV_ACCEL :
							run.decel ? dbvcp_pkg::FC_UV_DECEL :
							dbvcp_pkg::FC_UV_CONST;
					end
					else if (uvNow)
					begin
						state_q <= dbvcp_pkg::ST_STOPWARN;
						stopWarn <= 1'b1;
						faultCode <= dbvcp_pkg::FC_UV_STOP;
					end
				dbvcp_pkg::ST_STOPWARN:
					if (recovered)
					begin
						state_q <= dbvcp_pkg::ST_NORMAL;
						stopWarn <= 1'b0;
						faultCode <= dbvcp_pkg::FC_NONE;
					end
				dbvcp_pkg::ST_OPFAULT:
					if (resetCmd | (restartEn_q & recovered))
					begin
						state_q <= dbvcp_pkg::ST_NORMAL;
						coastReq <= 1'b0;
						faultCode <= dbvcp_pkg::FC_NONE;
						restartReq <= ~resetCmd;
					end
				default:
				begin
					state_q <= dbvcp_pkg::ST_NORMAL;
					coastReq <= 1'b0;
					stopWarn <= 1'b0;
				end
			endcase
		end
	end

	// event pulses feeding the sticky bits
	assign irqEvt[dbvcp_pkg::IRQ_UV_FAULT] = faultLog;
	assign irqEvt[dbvcp_pkg::IRQ_UV_STOP] =
		(state_q == dbvcp_pkg::ST_NORMAL) & uvNow & ~run.running;
	assign irqEvt[dbvcp_pkg::IRQ_OV_STALL] = (tradHold | smartHold) & ~ovStall_q;
	assign irqEvt[dbvcp_pkg::IRQ_OC_STALL] = ocHold & ~ocStall_q;

	// ************************************************************
	// read mux
	// ************************************************************
	always_comb
	begin
		rdVal = 32'h0000_0000;
		rdHit = 1'b1;
		if (isReg(s_axi_araddr, dbvcp_pkg::IDX_LV_THRESH))
			rdVal[15:0] = lvThresh_q;
		else if (isReg(s_axi_araddr, dbvcp_pkg::IDX_OV_LEVEL))
			rdVal[15:0] = ovLevel_q;
		else if (isReg(s_axi_araddr, dbvcp_pkg::IDX_OV_METHOD))
			rdVal[0] = ovMethod_q;
		else if (isReg(s_axi_araddr, dbvcp_pkg::IDX_OC_LEVEL))
			rdVal[15:0] = ocLevel_q;
		else if (isReg(s_axi_araddr, dbvcp_pkg::IDX_CTRL))
			rdVal[1:0] = {restartEn_q, torqueCt_q};
		else if (isReg(s_axi_araddr, dbvcp_pkg::IDX_STATUS))
			rdVal[8:0] = {ocStall_q, ovStall_q, rampHold, stopWarn,
				coastReq, state_q == dbvcp_pkg::ST_OPFAULT, faultCode};
		else if (isReg(s_axi_araddr, dbvcp_pkg::IDX_IRQ_STAT))
			rdVal[dbvcp_pkg::IRQ_W-1:0] = irqStat_q;
		else if (isReg(s_axi_araddr, dbvcp_pkg::IDX_IRQ_MASK))
			rdVal[dbvcp_pkg::IRQ_W-1:0] = irqMask_q;
		else if (!isReg(s_axi_araddr, dbvcp_pkg::IDX_CMD))
			rdHit = 1'b0;
	end

	// ************************************************************
	// checks
	// ************************************************************
	chk_uv_coast_entry: assert property (@(posedge core_clk)
		disable iff (srst)
		state_q == dbvcp_pkg::ST_NORMAL && uvNow && run.running |=> coastReq)
		else $error("undervoltage while running did not coast");
	chk_uv_accel_code: assert property (@(posedge core_clk)
		disable iff (srst)
		state_q == dbvcp_pkg::ST_NORMAL && uvNow && run.running && run.accel
		|=> faultCode == dbvcp_pkg::FC_UV_ACCEL)
		else $error("wrong code for undervoltage in acceleration");
	chk_fault_latch_hold: assert property (@(posedge core_clk)
		disable iff (srst)
		state_q == dbvcp_pkg::ST_OPFAULT && !resetCmd && !restartEn_q
		|=> state_q == dbvcp_pkg::ST_OPFAULT && coastReq)
		else $error("latched fault released without reset");
	chk_stop_no_log: assert property (@(posedge core_clk)
		disable iff (srst)
		stopWarn |-> !faultLog && faultCode == dbvcp_pkg::FC_UV_STOP)
		else $error("stopped undervoltage logged or miscoded");
	chk_stop_recover_exit: assert property (@(posedge core_clk)
		disable iff (srst)
		state_q == dbvcp_pkg::ST_STOPWARN && recovered |=> !stopWarn)
		else $error("stopped undervoltage did not recover");
	chk_ov_zero_off: assert property (@(posedge core_clk)
		disable iff (srst)
		ovLevel_q == 16'h0000 |=> !ovStall_q)
		else $error("overvoltage stall active with zero level");
	chk_ov_above_fault: assert property (@(posedge core_clk)
		disable iff (srst)
		ovLevel_q > OV_FAULT |=> !rampExtend)
		else $error("overvoltage stall active above fault level");
	chk_trad_pause: assert property (@(posedge core_clk)
		disable iff (srst)
		run.decel && ovEnable && !ovMethod_q && meas.busVolt > ovLevel_q
		|=> rampHold && rampExtend)
		else $error("traditional stall did not pause the ramp");
	chk_oc_freeze: assert property (@(posedge core_clk)
		disable iff (srst)
		run.accel && meas.outCurrent > ocEff |=> rampHold)
		else $error("over-current did not freeze acceleration");
	chk_oc_ct_cap: assert property (@(posedge core_clk)
		disable iff (srst)
		torqueCt_q && meas.busVolt > OC_CAP_V |-> ocEff <= dbvcp_pkg::OC_CAP_CT)
		else $error("constant torque level not capped");

endmodule
`default_nettype wire

//--- bench/dbvcp_power_stage.sv
// power stage and bus measurement model at the far side of the block
// assumes the bench sets bus voltage, current and run state each cycle
`timescale 1ns/100ps
`default_nettype none
module dbvcp_power_stage (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [15:0] setVolt,
	input wire logic [15:0] setCur,
	input wire dbvcp_pkg::dbvcp_run_t setRun,
	input wire logic coastReq,
	output dbvcp_pkg::dbvcp_meas_t meas,
	output dbvcp_pkg::dbvcp_run_t run
);
	// measurements sampled once a cycle, like a converter feeding the core
	always_ff @(posedge core_clk)
	begin
		meas.busVolt <= setVolt;
		meas.outCurrent <= setCur;
	end

	// a coasting motor has no ramp left, only the run flag stays
	always_ff @(posedge core_clk)
	begin
		if (srst)
			run <= '0;
		else if (coastReq)
			run <= {setRun.running, 2'b00};
		else
			run <= setRun;
	end
endmodule
`default_nettype wire

//--- bench/dbvcp_protect_tb.sv
// self-checking bench for the bus protection block, low voltage series
// assumes the package, the design and the power stage model compile first
`timescale 1ns/100ps
`default_nettype none
module dbvcp_protect_tb;
	// ****************************************************
	// clock, bus signals and bench state
	// ****************************************************
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic [15:0] awAddr = 16'h0000;
	logic [15:0] arAddr = 16'h0000;
	logic [31:0] wData = 32'h00000000;
	logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
	logic arValid = 1'b0, rReady = 1'b0;
	logic awReady, wReady, bValid, arReady, rValid;
	logic [1:0] bResp, rResp, rdResp, wrResp;
	logic [31:0] rData, rdData;
	logic [15:0] setVolt = 16'h0bb8, setCur = 16'h0000;
	dbvcp_pkg::dbvcp_run_t setRun = '0, r;
	dbvcp_pkg::dbvcp_meas_t meas;
	dbvcp_pkg::dbvcp_run_t run;
	logic coastReq, rampHold, rampExtend, stopWarn, faultLog, restartReq, irq;
	logic [2:0] faultCode;
	int error_cnt = 0, total_checks = 0, logCnt = 0, rstCnt = 0;
	logic [31:0] seed = 32'h0000c224; // fixed start
	logic [15:0] thr, lvl, v, lim, c;
	logic ct, m;

	always #5 core_clk = ~core_clk;

	dbvcp_protect #(.HIGH_VOLT(1'b0)) dbvcp_protect_i (.core_clk(core_clk),
		.srst(srst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .meas(meas), .run(run), .coastReq(coastReq),
		.rampHold(rampHold), .rampExtend(rampExtend), .faultCode(faultCode),
		.stopWarn(stopWarn), .faultLog(faultLog), .restartReq(restartReq),
		.irq(irq));

	dbvcp_power_stage dbvcp_power_stage_i (.core_clk(core_clk), .srst(srst),
		.setVolt(setVolt), .setCur(setCur), .setRun(setRun),
		.coastReq(coastReq), .meas(meas), .run(run));

	// count history and restart pulses
	always @(posedge core_clk)
	begin
		if (faultLog === 1'b1)
			logCnt++;
		if (restartReq === 1'b1)
			rstCnt++;
	end

	// ****************************************************
	// expectation functions and bus tasks
	// ****************************************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [2:0] uvCode(input dbvcp_pkg::dbvcp_run_t q);
		if (q.accel)
			return dbvcp_pkg::FC_UV_ACCEL;
		return q.decel ? dbvcp_pkg::FC_UV_DECEL : dbvcp_pkg::FC_UV_CONST;
	endfunction

	function automatic logic ovHold(input logic [15:0] l, input logic md,
		input logic [15:0] vv);
		if (l == 16'h0000 || l > dbvcp_pkg::OV_FAULT_LO)
			return 1'b0;
		return md ? (vv + dbvcp_pkg::SMART_BAND > l) : (vv > l);
	endfunction

	function automatic logic [15:0] ocLim(input logic [15:0] l,
		input logic t, input logic [15:0] vv);
		logic [15:0] mx;
		mx = t ? dbvcp_pkg::OC_MAX_CT : dbvcp_pkg::OC_MAX_VT;
		if (t && vv > dbvcp_pkg::OC_CAP_V_LO)
			mx = dbvcp_pkg::OC_CAP_CT;
		return (l < mx) ? l : mx;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic tmo(input int n);
		if (n >= 50)
		begin
			error_cnt++;
			$display("[FAIL] %0t bus answer timed out", $time);
			summarize();
		end
	endtask

	task automatic wr(input logic [15:0] idx, input logic [15:0] d);
		int n;
		@(posedge core_clk);
		awAddr <= {idx[13:0], 2'b00};
		wData <= {16'h0000, d};
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge core_clk);
			if (awReady)
				awValid <= 1'b0;
			if (wReady)
				wValid <= 1'b0;
			if (bValid)
				break;
		end
		wrResp = bResp;
		bReady <= 1'b0;
		tmo(n);
	endtask

	task automatic rd(input logic [15:0] idx);
		int n;
		@(posedge core_clk);
		arAddr <= {idx[13:0], 2'b00};
		arValid <= 1'b1;
		rReady <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge core_clk);
			if (arReady)
				arValid <= 1'b0;
			if (rValid)
				break;
		end
		rdData = rData;
		rdResp = rResp;
		rReady <= 1'b0;
		tmo(n);
	endtask

	// model latches one cycle, the block answers one later
	task automatic drive(input dbvcp_pkg::dbvcp_run_t q, input logic [15:0] vv,
		input logic [15:0] cc);
		@(posedge core_clk);
		setRun <= q;
		setVolt <= vv;
		setCur <= cc;
		repeat (4) @(posedge core_clk);
	endtask

	// ****************************************************
	// main sequence
	// ****************************************************
	initial
	begin
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		rd(dbvcp_pkg::IDX_LV_THRESH);
		chk(rdData, {16'h0000, dbvcp_pkg::LV_DEF_LO});
		rd(dbvcp_pkg::IDX_OV_LEVEL);
		chk(rdData, {16'h0000, dbvcp_pkg::OVS_DEF_LO});
		rd(dbvcp_pkg::IDX_OV_METHOD);
		chk(rdData, 32'h00000000);
		rd(dbvcp_pkg::IDX_OC_LEVEL);
		chk(rdData, {16'h0000, dbvcp_pkg::OC_DEF_VT});
		rd(16'h06ff);
		chk(32'(rdResp), 32'(dbvcp_pkg::RESP_SLVERR));
		wr(16'h06ff, 16'h0001);
		chk(32'(wrResp), 32'(dbvcp_pkg::RESP_SLVERR));
		$display("test reset done");

		thr = 16'h05dc + 16'(rnd() % 32'h2bd);
		wr(dbvcp_pkg::IDX_LV_THRESH, thr);
		chk(32'(wrResp), 32'(dbvcp_pkg::RESP_OKAY));
		wr(dbvcp_pkg::IDX_IRQ_MASK, 16'h0001);
		drive(3'b100, thr, 16'h0000);
		chk(32'(faultCode), 32'(dbvcp_pkg::FC_NONE));
		for (int k = 0; k < 3; k++)
		begin
			r = {1'b1, k == 0, k == 1};
			drive(r, thr - 16'h0001 - 16'(rnd() % 32'h64), 16'h0000);
			chk(32'(faultCode), 32'(uvCode(r)));
			chk(32'(coastReq), 32'h1);
			chk(32'(logCnt), 32'(k + 1));
			rd(dbvcp_pkg::IDX_STATUS);
			chk(rdData, 32'h00000018 | 32'(uvCode(r)));
			drive(r, thr + 16'h0190, 16'h0000);
			chk(32'(faultCode), 32'(uvCode(r)));
			chk(32'(irq), 32'h1);
			wr(dbvcp_pkg::IDX_CMD, 16'h0001);
			repeat (2) @(posedge core_clk);
			chk(32'(coastReq), 32'h0);
		end
		wr(dbvcp_pkg::IDX_IRQ_STAT, 16'h0001);
		repeat (2) @(posedge core_clk);
		chk(32'(irq), 32'h0);
		$display("test running undervoltage done");

		drive(3'b000, thr - 16'h0005, 16'h0000);
		chk(32'(faultCode), 32'(dbvcp_pkg::FC_UV_STOP));
		chk(32'({stopWarn, coastReq}), 32'h2);
		chk(32'(logCnt), 32'h3);
		rd(dbvcp_pkg::IDX_IRQ_STAT);
		chk(rdData, 32'h00000002);
		chk(32'(irq), 32'h0);
		drive(3'b000, thr + dbvcp_pkg::HYST_LO, 16'h0000);
		chk(32'(faultCode), 32'(dbvcp_pkg::FC_UV_STOP));
		drive(3'b000, thr + dbvcp_pkg::HYST_LO + 16'h0001, 16'h0000);
		chk(32'(faultCode), 32'(dbvcp_pkg::FC_NONE));
		$display("test stopped undervoltage done");

		wr(dbvcp_pkg::IDX_CTRL, 16'h0002);
		drive(3'b100, thr - 16'h0001, 16'h0000);
		chk(32'(faultCode), 32'(dbvcp_pkg::FC_UV_CONST));
		drive(3'b100, thr + dbvcp_pkg::HYST_LO + 16'h0001, 16'h0000);
		chk(32'(faultCode), 32'(dbvcp_pkg::FC_NONE));
		chk(32'(rstCnt), 32'h1);
		$display("test restart done");

		for (int k = 0; k < 24; k++)
		begin
			case (rnd() % 4)
				0: lvl = 16'h0000;
				1: lvl = 16'h1004;
				2: lvl = 16'h1005;
				default: lvl = 16'h09c4 + 16'(rnd() % 32'h578);
			endcase
			v = (lvl == 16'h0000) ? 16'h0bb8 : lvl;
			v = v - 16'h0066 + 16'(rnd() % 32'hce);
			m = 1'(rnd());
			wr(dbvcp_pkg::IDX_OV_LEVEL, lvl);
			wr(dbvcp_pkg::IDX_OV_METHOD, {15'h0000, m});
			drive(3'b101, v, 16'h0000);
			chk(32'(rampHold), 32'(ovHold(lvl, m, v)));
			chk(32'(rampExtend), 32'(ovHold(lvl, m, v)));
		end
		$display("test overvoltage stall done");

		for (int k = 0; k < 24; k++)
		begin
			ct = 1'(rnd());
			lvl = 16'(rnd() % 32'hff);
			v = 16'h0d70 + 16'(rnd() % 32'h78);
			wr(dbvcp_pkg::IDX_CTRL, {15'h0000, ct});
			wr(dbvcp_pkg::IDX_OC_LEVEL, lvl);
			rd(dbvcp_pkg::IDX_OC_LEVEL);
			chk(rdData, {16'h0000, ocLim(lvl, ct, 16'h0000)});
			lim = ocLim(lvl, ct, v);
			c = lim - 16'h0001 + 16'(rnd() % 32'h3);
			drive(3'b110, v, c);
			chk(32'(rampHold), 32'(c > lim));
		end
		$display("test overcurrent stall done");
		summarize();
	end
endmodule
`default_nettype wire
